// ### verilog/rssm_top.sv
// remote station status, monitor and command register bank with ahb-lite slave
// Functional notes
// - stop-error flag sets when the station reports a stop-class error.
// - continue-error flag sets when the station reports a continue-class error.
// - both flags clear on accepted error reset or station power-up.
// - on any detected error the station's error code is stored.
// - stored error code clears to zero on accepted reset or power-up.
// - run state reads 0 no link, 1 stopped, 2 running, 3 error.
// - total retry count increments on every communication retry; the code holds it at 65535 instead of wrapping.
// - consecutive retry count increments per retry, zero on success; the code holds it at 65535 instead of wrapping.
// - monitor block spans ten words; words four to nine read zero.
// - command word is sixteen bits, bit 7 error reset, rest reserved.
// - error reset clears the stored code and the error flags.
// - station may refuse reset; code and flags then stay.
// - status word has stop at bit 7, continue at bit 15.
`default_nettype none
module rssm_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [rssm_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic op_tick,
  input wire logic main_tick,
  input wire logic stn_link_up,
  input wire logic stn_running,
  input wire logic stn_stop_err,
  input wire logic stn_cont_err,
  input wire logic [15:0] stn_err_code,
  input wire logic stn_reset_refused,
  input wire logic stn_power_up,
  input wire logic stn_retry,
  input wire logic stn_comm_ok,
  output logic err_reset_req,
  output logic irq
);
  logic stop_r;
  logic cont_r;
  logic [15:0] fault_code_r;
  logic [15:0] run_state_r;
  logic [15:0] retry_total_r;
  logic [15:0] retry_run_r;
  logic [15:0] cmd_word_r;
  logic rst_cmd_r;
  logic [rssm_pkg::IRQ_W-1:0] irq_stat_r;
  logic [rssm_pkg::IRQ_W-1:0] irq_mask_r;
  logic [rssm_pkg::IRQ_W-1:0] irq_ev;
  logic wr_pend_r;
  logic [3:0] wr_idx_r;
  logic [31:0] rdata_nxt;
  logic [3:0] a_idx;
  logic a_hi_zero;
  logic addr_ok;
  logic rd_take;
  logic clr_ok;
  logic err_seen;
  logic flags_clear;

  assign a_idx = haddr[rssm_pkg::IDX_LSB +: 4];
  // every address bit above the byte lane is index, so mapped means index within the register map
  assign a_hi_zero = (a_idx <= rssm_pkg::IDX_IRQ_MASK);
  assign addr_ok = hsel && hready && (htrans == rssm_pkg::HTRANS_NONSEQ);
  assign rd_take = ce && addr_ok && !hwrite;
  // a refused reset leaves code and flags untouched; power-up clears even if refused, but a report in that cycle wins
  assign clr_ok = (op_tick && rst_cmd_r && !stn_reset_refused) || stn_power_up;
  assign err_seen = op_tick && (stn_stop_err || stn_cont_err);
  assign flags_clear = clr_ok && (stop_r || cont_r);

  // bus: zero wait state, always okay; reads are answered from a flop in the data phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hreadyout <= 1'b0;
      hresp <= rssm_pkg::HRESP_OKAY;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= rssm_pkg::HRESP_OKAY;
    end
  end

  always_comb begin
    rdata_nxt = rssm_pkg::ZERO32;
    if (a_hi_zero) begin
      unique case (a_idx)
        rssm_pkg::IDX_RUN_STATE: rdata_nxt[15:0] = run_state_r;
        rssm_pkg::IDX_FAULT_CODE: rdata_nxt[15:0] = fault_code_r;
        rssm_pkg::IDX_RETRY_TOTAL: rdata_nxt[15:0] = retry_total_r;
        rssm_pkg::IDX_RETRY_RUN: rdata_nxt[15:0] = retry_run_r;
        rssm_pkg::IDX_STATUS: begin
          rdata_nxt[rssm_pkg::BIT_STOP_ERR] = stop_r;
          rdata_nxt[rssm_pkg::BIT_CONT_ERR] = cont_r;
        end
        rssm_pkg::IDX_COMMAND: rdata_nxt[15:0] = cmd_word_r;
        rssm_pkg::IDX_IRQ_STAT: rdata_nxt[rssm_pkg::IRQ_W-1:0] = irq_stat_r;
        rssm_pkg::IDX_IRQ_MASK: rdata_nxt[rssm_pkg::IRQ_W-1:0] = irq_mask_r;
        // monitor words four to nine and unmapped words read zero
        default: rdata_nxt = rssm_pkg::ZERO32;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= rssm_pkg::ZERO32;
    end else if (rd_take) begin
      hrdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 4'h0;
    end else if (ce) begin
      wr_pend_r <= addr_ok && hwrite && a_hi_zero;
      wr_idx_r <= a_idx;
    end
  end

  // only the reset bit is writable, reserved bits stay zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_word_r <= rssm_pkg::ZERO16;
    end else if (ce && wr_pend_r && wr_idx_r == rssm_pkg::IDX_COMMAND) begin
      cmd_word_r <= rssm_pkg::ZERO16;
      cmd_word_r[rssm_pkg::BIT_ERR_RESET] <= hwdata[rssm_pkg::BIT_ERR_RESET];
    end
  end

  // command is looked at only once per main cycle, as a level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_cmd_r <= 1'b0;
      err_reset_req <= 1'b0;
    end else if (ce && main_tick) begin
      rst_cmd_r <= cmd_word_r[rssm_pkg::BIT_ERR_RESET];
      err_reset_req <= cmd_word_r[rssm_pkg::BIT_ERR_RESET];
    end
  end

  // error flags: a report in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stop_r <= 1'b0;
      cont_r <= 1'b0;
    end else if (ce) begin
      if (op_tick && stn_stop_err) begin
        stop_r <= 1'b1;
      end else if (clr_ok) begin
        stop_r <= 1'b0;
      end
      if (op_tick && stn_cont_err) begin
        cont_r <= 1'b1;
      end else if (clr_ok) begin
        cont_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fault_code_r <= rssm_pkg::ZERO16;
    end else if (ce) begin
      if (err_seen) begin
        fault_code_r <= stn_err_code;
      end else if (clr_ok) begin
        fault_code_r <= rssm_pkg::ZERO16;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_state_r <= rssm_pkg::ST_NO_COMM;
    end else if (ce && op_tick) begin
      if (!stn_link_up) begin
        run_state_r <= rssm_pkg::ST_NO_COMM;
      end else if (stn_stop_err || stn_cont_err || stop_r || cont_r) begin
        run_state_r <= rssm_pkg::ST_ERROR;
      end else if (stn_running) begin
        run_state_r <= rssm_pkg::ST_RUNNING;
      end else begin
        run_state_r <= rssm_pkg::ST_STOPPED;
      end
    end
  end

  // counters saturate rather than wrap so a long outage never reads as few retries
  always_ff @(posedge clk) begin
    if (!rstn) begin
      retry_total_r <= rssm_pkg::ZERO16;
      retry_run_r <= rssm_pkg::ZERO16;
    end else if (ce) begin
      if (stn_retry && retry_total_r != rssm_pkg::MAX16) begin
        retry_total_r <= retry_total_r + rssm_pkg::ONE16;
      end
      if (stn_retry) begin
        if (retry_run_r != rssm_pkg::MAX16) begin
          retry_run_r <= retry_run_r + rssm_pkg::ONE16;
        end
      end else if (stn_comm_ok) begin
        retry_run_r <= rssm_pkg::ZERO16;
      end
    end
  end

  assign irq_ev[rssm_pkg::EV_STOP] = op_tick && stn_stop_err && !stop_r;
  assign irq_ev[rssm_pkg::EV_CONT] = op_tick && stn_cont_err && !cont_r;
  assign irq_ev[rssm_pkg::EV_RETRY] = stn_retry;
  assign irq_ev[rssm_pkg::EV_CLEARED] = flags_clear;

  // read of the interrupt status word clears it; a new event in that cycle survives
  genvar gi;
  generate
    for (gi = 0; gi < rssm_pkg::IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clk) begin
        if (!rstn) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (ce) begin
          if (irq_ev[gi]) begin
            irq_stat_r[gi] <= 1'b1;
          end else if (rd_take && a_hi_zero && a_idx == rssm_pkg::IDX_IRQ_STAT) begin
            irq_stat_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_mask_r <= '0;
    end else if (ce && wr_pend_r && wr_idx_r == rssm_pkg::IDX_IRQ_MASK) begin
      irq_mask_r <= hwdata[rssm_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_stop_flag_set: assert property (ce && op_tick && stn_stop_err |=> stop_r)
    else $error("stop flag not set by stop error");
  a_cont_flag_set: assert property (ce && op_tick && stn_cont_err |=> cont_r)
    else $error("continue flag not set by continue error");
  a_reset_clears_all: assert property (ce && op_tick && rst_cmd_r && !stn_reset_refused && !stn_stop_err
      && !stn_cont_err |=> !stop_r && !cont_r && fault_code_r == rssm_pkg::ZERO16)
    else $error("accepted reset did not clear flags and code");
  a_power_clears_code: assert property (ce && stn_power_up && !err_seen
      |=> fault_code_r == rssm_pkg::ZERO16 && !stop_r && !cont_r)
    else $error("power-up did not clear code");
  a_code_stored: assert property (ce && err_seen |=> fault_code_r == $past(stn_err_code))
    else $error("error code not stored");
  a_refused_holds: assert property (ce && stop_r && stn_reset_refused && !stn_power_up && !err_seen
      |=> stop_r && $stable(fault_code_r))
    else $error("refused reset changed flag or code");
  a_reset_needs_cmd: assert property (ce && stop_r && !rst_cmd_r && !stn_power_up |=> stop_r)
    else $error("flag dropped without reset");
  a_state_code: assert property (ce && op_tick && stn_link_up && !stn_stop_err && !stn_cont_err && !stop_r
      && !cont_r |=> run_state_r == (stn_running ? rssm_pkg::ST_RUNNING : rssm_pkg::ST_STOPPED))
    else $error("run state code wrong");
  a_total_count: assert property (ce && stn_retry && retry_total_r != rssm_pkg::MAX16
      |=> retry_total_r == $past(retry_total_r) + rssm_pkg::ONE16)
    else $error("total retry count not incremented");
  a_run_zeroed: assert property (ce && stn_comm_ok && !stn_retry |=> retry_run_r == rssm_pkg::ZERO16)
    else $error("run retry count not zeroed");
  a_cmd_level: assert property (ce && main_tick
      |=> err_reset_req == $past(cmd_word_r[rssm_pkg::BIT_ERR_RESET]))
    else $error("reset command not sampled on main tick");
  a_cmd_reserved: assert property (cmd_word_r[rssm_pkg::BIT_ERR_RESET-1:0] == '0
      && cmd_word_r[15:rssm_pkg::BIT_ERR_RESET+1] == '0)
    else $error("reserved command bit set");
endmodule // rssm_top
`default_nettype wire

// ### verilog/rssm_pkg.sv
// constants for the remote station status monitor
`default_nettype none
package rssm_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 6;
  // register indices, byte address is index times four
  localparam logic [3:0] IDX_RUN_STATE = 4'h0;
  localparam logic [3:0] IDX_FAULT_CODE = 4'h1;
  localparam logic [3:0] IDX_RETRY_TOTAL = 4'h2;
  localparam logic [3:0] IDX_RETRY_RUN = 4'h3;
  localparam logic [3:0] IDX_MON_LAST = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'hA;
  localparam logic [3:0] IDX_COMMAND = 4'hB;
  localparam logic [3:0] IDX_IRQ_STAT = 4'hC;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hD;
  localparam int unsigned IDX_LSB = 2;
  // status and command bit positions
  localparam int unsigned BIT_STOP_ERR = 7;
  localparam int unsigned BIT_CONT_ERR = 15;
  localparam int unsigned BIT_ERR_RESET = 7;
  // run state codes
  localparam logic [15:0] ST_NO_COMM = 16'h0000;
  localparam logic [15:0] ST_STOPPED = 16'h0001;
  localparam logic [15:0] ST_RUNNING = 16'h0002;
  localparam logic [15:0] ST_ERROR = 16'h0003;
  // interrupt event bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_STOP = 0;
  localparam int unsigned EV_CONT = 1;
  localparam int unsigned EV_RETRY = 2;
  localparam int unsigned EV_CLEARED = 3;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] MAX16 = 16'hFFFF;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

// ### verif/rssm_station_model.sv
// behavioural remote head station feeding error reports to the monitor
`default_nettype none
module rssm_station_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inj_stop,
  input wire logic inj_cont,
  input wire logic [15:0] inj_code,
  input wire logic refuse,
  input wire logic err_reset_req,
  input wire logic stn_power_up,
  output logic stn_stop_err,
  output logic stn_cont_err,
  output logic [15:0] stn_err_code,
  output logic stn_reset_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] code_r;
  assign stn_reset_refused = refuse;
  // code is only meaningful with a report; otherwise show its inverse so stale values never match
  assign stn_err_code = (stn_stop_err || stn_cont_err) ? code_r : ~code_r;
  always_ff @(posedge clk) begin
    if (!rstn || stn_power_up || (err_reset_req && !refuse)) begin
      stn_stop_err <= 1'b0;
      stn_cont_err <= 1'b0;
    end else begin
      if (inj_stop) stn_stop_err <= 1'b1;
      if (inj_cont) stn_cont_err <= 1'b1;
    end
    if (!rstn) code_r <= 16'h0000;
    else if (inj_stop || inj_cont) code_r <= inj_code;
  end
endmodule // rssm_station_model
`default_nettype wire

// ### verif/test_rssm_top.sv
// self-checking bench for the remote station status monitor
`default_nettype none
module test_rssm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, ce = 1, hsel = 0, hwrite = 0, hresp, hreadyout, irq, err_reset_req;
  logic [5:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, d;
  logic op_tick = 0, main_tick = 0, link_up = 0, running = 0, retry = 0, ok = 0, pwr = 0;
  logic inj_stop = 0, inj_cont = 0, refuse = 0, stop_err, cont_err, refused;
  logic [15:0] inj_code = 0, code;
  int miscompares = 0, tests_run = 0, cyc = 0;
  rssm_top rssm_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_tick(op_tick), .main_tick(main_tick), .stn_link_up(link_up),
    .stn_running(running), .stn_stop_err(stop_err), .stn_cont_err(cont_err), .stn_err_code(code),
    .stn_reset_refused(refused), .stn_power_up(pwr), .stn_retry(retry), .stn_comm_ok(ok),
    .err_reset_req(err_reset_req), .irq(irq));
  rssm_station_model rssm_station_model_inst (.clk(clk), .rstn(rstn), .inj_stop(inj_stop), .inj_cont(inj_cont),
    .inj_code(inj_code), .refuse(refuse), .err_reset_req(err_reset_req), .stn_power_up(pwr),
    .stn_stop_err(stop_err), .stn_cont_err(cont_err), .stn_err_code(code), .stn_reset_refused(refused));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ticks are slow enough that waiting 40 cycles always spans two main cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    op_tick <= (cyc % 8) == 7;
    main_tick <= (cyc % 16) == 15;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rv);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= rssm_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic [31:0] dummy;
    bus(a, 1'b1, v, dummy);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    bus(a, 1'b0, 32'h0000_0000, v);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: retry <= 1'b1;
      1: ok <= 1'b1;
      default: pwr <= 1'b1;
    endcase
    @(posedge clk);
    {retry, ok, pwr} <= 3'b000;
  endtask
  task automatic wt;
    repeat (40) @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      rd(6'(i * 4), d);
      chk("reset_map", d, 32'h0000_0000);
    end
    wr(6'h10, 32'h0000_FFFF);
    rd(6'h10, d);
    chk("reserved_word", d, 32'h0000_0000);
    wr(6'h2C, 32'h0000_FF7F);
    rd(6'h2C, d);
    chk("cmd_reserved", d, 32'h0000_0000);
    link_up <= 1'b1;
    wt();
    rd(6'h00, d);
    chk("state_stopped", d, {16'h0000, rssm_pkg::ST_STOPPED});
    running <= 1'b1;
    wt();
    rd(6'h00, d);
    chk("state_running", d, {16'h0000, rssm_pkg::ST_RUNNING});
    wr(6'h34, 32'h0000_000F);
    inj_code <= 16'h1234;
    inj_stop <= 1'b1;
    @(posedge clk);
    inj_stop <= 1'b0;
    wt();
    rd(6'h28, d);
    chk("status_stop", d, 32'h0000_0080);
    rd(6'h04, d);
    chk("code_stop", d, 32'h0000_1234);
    rd(6'h00, d);
    chk("state_error", d, {16'h0000, rssm_pkg::ST_ERROR});
    chk("irq_on", irq, 32'h0000_0001);
    rd(6'h30, d);
    chk("irq_stat_stop", d, 32'h0000_0001);
    rd(6'h30, d);
    chk("irq_stat_clear", d, 32'h0000_0000);
    chk("irq_off", irq, 32'h0000_0000);
    refuse <= 1'b1;
    wr(6'h2C, 32'h0000_0080);
    wt();
    chk("reset_level", err_reset_req, 32'h0000_0001);
    rd(6'h28, d);
    chk("refused_flag", d, 32'h0000_0080);
    rd(6'h04, d);
    chk("refused_code", d, 32'h0000_1234);
    refuse <= 1'b0;
    wt();
    rd(6'h28, d);
    chk("reset_flag", d, 32'h0000_0000);
    rd(6'h04, d);
    chk("reset_code", d, 32'h0000_0000);
    rd(6'h30, d);
    chk("irq_stat_cleared", d, 32'h0000_0008);
    wr(6'h2C, 32'h0000_0000);
    wt();
    chk("reset_release", err_reset_req, 32'h0000_0000);
    inj_code <= 16'h0BEE;
    inj_cont <= 1'b1;
    @(posedge clk);
    inj_cont <= 1'b0;
    wt();
    rd(6'h28, d);
    chk("status_cont", d, 32'h0000_8000);
    rd(6'h04, d);
    chk("code_cont", d, 32'h0000_0BEE);
    // a report in the same op tick beats the clear, so a second pulse finishes it
    pulse(2);
    pulse(2);
    rd(6'h28, d);
    chk("power_flag", d, 32'h0000_0000);
    rd(6'h04, d);
    chk("power_code", d, 32'h0000_0000);
    rd(6'h30, d);
    wr(6'h34, 32'h0000_0000);
    repeat (3) pulse(0);
    rd(6'h08, d);
    chk("retry_total3", d, 32'h0000_0003);
    rd(6'h0C, d);
    chk("retry_run3", d, 32'h0000_0003);
    chk("irq_masked", irq, 32'h0000_0000);
    pulse(1);
    rd(6'h0C, d);
    chk("retry_run_ok", d, 32'h0000_0000);
    pulse(0);
    rd(6'h08, d);
    chk("retry_total4", d, 32'h0000_0004);
    rd(6'h0C, d);
    chk("retry_run1", d, 32'h0000_0001);
    wr(6'h34, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk("irq_unmasked", irq, 32'h0000_0001);
    rd(6'h30, d);
    chk("irq_stat_retry", d, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk("irq_read_clear", irq, 32'h0000_0000);
    chk("hresp_okay", hresp, 32'h0000_0000);
    chk("hready_high", hreadyout, 32'h0000_0001);
    end_of_test();
  end
endmodule // test_rssm_top
`default_nettype wire
